/* File: rtl/acp_channel_ctrl.sv */
// Channel clock path control: phase adjust, output status, APLL config
// Overview of operation
// R1: Finished flag reaches channel interrupt only while its enable is one.
// R2: Finished flag latches when adjustment completes; write one clears.
// R3: Software polls busy, not finished, in short-period configurations.
// R4: Busy bit is high from trigger until adjustment ends.
// R5: Armed bit high while waiting for trigger, cleared by trigger.
// R6: Three output status registers at 53h, 54h, 55h.
// R7: Slow edge flag latches on slow clock rising edge; write one clears.
// R8: With report enable, real-time bit shows slow level, one means low.
// R9: Resume flag latches when output restarts after stop; write one clears.
// R10: Halt flag latches when output stops; write one clears.
// R11: Halt state bit is one while stopped, zero while running.
// R12: Each output flag reaches interrupt only with its enable set.
// R13: Start and stop bits settle to zero until path is clocked.
// R14: Second divider runs only with PLL enable, its enable, no bypass.
// R15: Bypass bit selects bypass signal instead of second divider output.
// R16: Codes 0-7 give ratios 4 to 7.5, codes 8-15 give 8 to 15.
// R17: With pin switching, pin high selects alternate code, else primary.
// R18: Codes 000-011 select crystal, first, second, third input.
// R19: Codes 110/111/100 feed NCO; bypass gets XA, none, first input.
// R20: Primary code rules unless switching enabled and pin high.
// R21: Phase summary interrupt is any enabled latched phase flag.
// R22: Code 101 with master from first input feeds NCO, no bypass.
// R23: Writing zero keeps flags; a coinciding event keeps flag set.
module acp_channel_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic [acp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic adjust_arm,
  input wire logic adjust_trigger,
  input wire logic [2:0] adjust_participate,
  input wire logic [2:0] adjust_output_done,
  input wire logic [2:0] slow_divider_clk,
  input wire logic [2:0] output_clock_stopped,
  input wire logic [2:0] output_path_ready,
  input wire logic [2:0] slow_level_report_enable,
  input wire logic pll_power_enable,
  input wire logic master_clock_from_input1,
  input wire logic xa_doubler_enable,
  input wire logic switch_pin_level,
  output logic phase_adjust_irq,
  output logic [2:0] output_clock_irq,
  output logic second_fast_divider_on,
  output logic second_fast_divider_bypass_sel,
  output logic [4:0] first_ratio_halves,
  output logic [4:0] second_ratio_halves,
  output logic [2:0] pll_ref_source,
  output logic [2:0] bypass_source,
  output logic xa_doubled
);
  import acp_pkg::*;

  typedef enum logic [1:0] {
    ACP_PA_IDLE, ACP_PA_ARMED, ACP_PA_BUSY
  } acp_pa_type;

  acp_pa_type pa_state_r;
  logic adjust_done_irq_enable_r;
  logic adjust_done_latched;
  logic adjust_finish;
  logic [2:0] cfg_r;
  logic [7:0] ratios_r;
  logic [6:0] select_r;
  logic [2:0] slow_edge_irq_enable_r;
  logic [2:0] resume_irq_enable_r;
  logic [2:0] halt_irq_enable_r;
  logic [2:0] slow_prev_r;
  logic [2:0] stopped_prev_r;
  logic [2:0] halt_state_r;
  logic [2:0] slow_edge_latched;
  logic [2:0] resume_latched;
  logic [2:0] halt_latched;
  logic [7:0] oc_status [NUM_OUTPUTS];
  logic [2:0] oc_wr;
  logic pa_wr;
  logic [2:0] active_code;

  assign pa_wr = reg_write && (reg_addr == PHASE_ADJUST_STATUS_ADDR);
  assign adjust_finish = (pa_state_r == ACP_PA_BUSY) &&
    ((adjust_output_done & adjust_participate) == adjust_participate);

  // Phase adjust sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pa_state_r <= ACP_PA_IDLE;
    end else begin
      case (pa_state_r)
        ACP_PA_IDLE: begin
          if (adjust_arm) begin
            pa_state_r <= ACP_PA_ARMED;
          end
        end
        ACP_PA_ARMED: begin
          if (adjust_trigger) begin
            pa_state_r <= ACP_PA_BUSY; // see R5
          end
        end
        ACP_PA_BUSY: begin
          if (adjust_finish) begin
            pa_state_r <= ACP_PA_IDLE; // see R4
          end
        end
        default: pa_state_r <= ACP_PA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      adjust_done_irq_enable_r <= PA_RESET[PA_DONE_IE_BIT];
    end else if (pa_wr) begin
      adjust_done_irq_enable_r <= reg_wdata[PA_DONE_IE_BIT];
    end
  end

  // see R2, R23
  acp_w1c_flag u_adjust_done (
    .clk(clk),
    .reset(reset),
    .set_pulse(adjust_finish),
    .clear_pulse(pa_wr && reg_wdata[PA_DONE_LATCHED_BIT]),
    .flag(adjust_done_latched)
  );

  // see R1, R21
  assign phase_adjust_irq = adjust_done_latched && adjust_done_irq_enable_r;

  // Per-output status logic
  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : g_out
      logic stop_evt;
      logic start_evt;
      logic slow_evt;
      logic clr_pulse;
      assign oc_wr[g] = reg_write &&
        (reg_addr == OUTPUT1_CLOCK_STATUS_ADDR + 9'(g)); // see R6
      // Until the path is clocked the stop logic only settles to zero
      assign stop_evt = output_path_ready[g] && output_clock_stopped[g] &&
        !stopped_prev_r[g]; // see R10
      assign start_evt = output_path_ready[g] && !output_clock_stopped[g] &&
        stopped_prev_r[g]; // see R9
      assign slow_evt = slow_divider_clk[g] && !slow_prev_r[g]; // see R7
      assign clr_pulse = oc_wr[g];

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          slow_edge_irq_enable_r[g] <= 1'b0;
          resume_irq_enable_r[g] <= 1'b0;
          halt_irq_enable_r[g] <= 1'b0;
        end else if (oc_wr[g]) begin
          slow_edge_irq_enable_r[g] <= reg_wdata[OC_SLOW_EDGE_IE_BIT];
          resume_irq_enable_r[g] <= reg_wdata[OC_RESUME_IE_BIT];
          halt_irq_enable_r[g] <= reg_wdata[OC_HALT_IE_BIT];
        end
      end

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          slow_prev_r[g] <= 1'b0;
          stopped_prev_r[g] <= 1'b0;
          halt_state_r[g] <= 1'b0;
        end else begin
          slow_prev_r[g] <= slow_divider_clk[g];
          if (output_path_ready[g]) begin
            stopped_prev_r[g] <= output_clock_stopped[g];
            halt_state_r[g] <= output_clock_stopped[g]; // see R11, R13
          end else begin
            stopped_prev_r[g] <= 1'b0;
            halt_state_r[g] <= 1'b0;
          end
        end
      end

      acp_w1c_flag u_slow (
        .clk(clk),
        .reset(reset),
        .set_pulse(slow_evt),
        .clear_pulse(clr_pulse && reg_wdata[OC_SLOW_EDGE_LATCHED_BIT]),
        .flag(slow_edge_latched[g])
      );
      acp_w1c_flag u_resume (
        .clk(clk),
        .reset(reset),
        .set_pulse(start_evt),
        .clear_pulse(clr_pulse && reg_wdata[OC_RESUME_LATCHED_BIT]),
        .flag(resume_latched[g])
      );
      acp_w1c_flag u_halt (
        .clk(clk),
        .reset(reset),
        .set_pulse(stop_evt),
        .clear_pulse(clr_pulse && reg_wdata[OC_HALT_LATCHED_BIT]),
        .flag(halt_latched[g])
      );

      // see R12
      assign output_clock_irq[g] =
        (slow_edge_latched[g] && slow_edge_irq_enable_r[g]) ||
        (resume_latched[g] && resume_irq_enable_r[g]) ||
        (halt_latched[g] && halt_irq_enable_r[g]);

      // Level bit reads zero when reporting is off; one means low
      assign oc_status[g] = {slow_edge_irq_enable_r[g], slow_edge_latched[g],
        slow_level_report_enable[g] && !slow_divider_clk[g], // see R8
        resume_irq_enable_r[g], resume_latched[g], halt_irq_enable_r[g],
        halt_latched[g], halt_state_r[g]};
    end
  endgenerate

  // Configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_r <= CFG_RESET[2:0];
      ratios_r <= CFG_RESET;
      select_r <= CFG_RESET[6:0];
    end else if (reg_write) begin
      if (reg_addr == APLL_DIVIDER_BYPASS_CONFIG_ADDR) begin
        cfg_r <= {reg_wdata[CFG_ENABLE_BIT:CFG_BYPASS_BIT], 1'b0};
      end
      if (reg_addr == APLL_HIGH_SPEED_RATIOS_ADDR) begin
        ratios_r <= reg_wdata;
      end
      if (reg_addr == APLL_INPUT_SELECT_ADDR) begin
        select_r <= reg_wdata[6:0];
      end
    end
  end

  // see R14
  assign second_fast_divider_on = pll_power_enable &&
    cfg_r[CFG_ENABLE_BIT] && !cfg_r[CFG_BYPASS_BIT];
  // see R15
  assign second_fast_divider_bypass_sel = cfg_r[CFG_BYPASS_BIT];

  // see R16
  acp_ratio_decode u_first_ratio (
    .code(ratios_r[3:0]),
    .ratio_halves(first_ratio_halves)
  );
  acp_ratio_decode u_second_ratio (
    .code(ratios_r[7:4]),
    .ratio_halves(second_ratio_halves)
  );

  // see R17, R20
  assign active_code = (select_r[SEL_SWITCH_BIT] && switch_pin_level) ?
    select_r[SEL_ALT_LSB +: 3] : select_r[SEL_PRIMARY_LSB +: 3];
  assign xa_doubled = xa_doubler_enable;

  // Alternate codes 100-111 are unused and select nothing
  always_comb begin
    pll_ref_source = ACP_REF_NONE;
    bypass_source = ACP_REF_NONE;
    case (active_code)
      SRC_XTAL: begin // see R18
        pll_ref_source = ACP_REF_XTAL;
        bypass_source = ACP_REF_XTAL;
      end
      SRC_IN1: begin
        pll_ref_source = ACP_REF_IN1;
        bypass_source = ACP_REF_IN1;
      end
      SRC_IN2: begin
        pll_ref_source = ACP_REF_IN2;
        bypass_source = ACP_REF_IN2;
      end
      SRC_IN3: begin
        pll_ref_source = ACP_REF_IN3;
        bypass_source = ACP_REF_IN3;
      end
      SRC_NCO_BYP_IN1: begin // see R19
        if (!(select_r[SEL_SWITCH_BIT] && switch_pin_level)) begin
          pll_ref_source = ACP_REF_NCO;
          bypass_source = ACP_REF_IN1;
        end
      end
      SRC_NCO_NO_BYP_MC1: begin // see R22
        if (!(select_r[SEL_SWITCH_BIT] && switch_pin_level) &&
            master_clock_from_input1) begin
          pll_ref_source = ACP_REF_NCO;
        end
      end
      SRC_NCO_BYP_XA: begin // see R19
        if (!(select_r[SEL_SWITCH_BIT] && switch_pin_level)) begin
          pll_ref_source = ACP_REF_NCO;
          bypass_source = ACP_REF_XTAL;
        end
      end
      SRC_NCO_NO_BYP: begin
        if (!(select_r[SEL_SWITCH_BIT] && switch_pin_level)) begin
          pll_ref_source = ACP_REF_NCO;
        end
      end
      default: begin
        pll_ref_source = ACP_REF_NONE;
      end
    endcase
  end

  // Read data registered one cycle after the read strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        PHASE_ADJUST_STATUS_ADDR: reg_rdata <= {4'h0,
          adjust_done_irq_enable_r, adjust_done_latched,
          pa_state_r == ACP_PA_BUSY, pa_state_r == ACP_PA_ARMED};
        OUTPUT1_CLOCK_STATUS_ADDR: reg_rdata <= oc_status[0];
        OUTPUT2_CLOCK_STATUS_ADDR: reg_rdata <= oc_status[1];
        OUTPUT3_CLOCK_STATUS_ADDR: reg_rdata <= oc_status[2];
        APLL_DIVIDER_BYPASS_CONFIG_ADDR: reg_rdata <= {5'h00, cfg_r};
        APLL_HIGH_SPEED_RATIOS_ADDR: reg_rdata <= ratios_r;
        APLL_INPUT_SELECT_ADDR: reg_rdata <= {1'b0, select_r};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

/* File: rtl/acp_pkg.sv */
// Package: register map, field positions, reset values and mux codes
package acp_pkg;
  localparam int ADDR_W = 9;
  localparam logic [8:0] PHASE_ADJUST_STATUS_ADDR = 9'h04d;
  localparam logic [8:0] OUTPUT1_CLOCK_STATUS_ADDR = 9'h053;
  localparam logic [8:0] OUTPUT2_CLOCK_STATUS_ADDR = 9'h054;
  localparam logic [8:0] OUTPUT3_CLOCK_STATUS_ADDR = 9'h055;
  localparam logic [8:0] APLL_DIVIDER_BYPASS_CONFIG_ADDR = 9'h100;
  localparam logic [8:0] APLL_HIGH_SPEED_RATIOS_ADDR = 9'h101;
  localparam logic [8:0] APLL_INPUT_SELECT_ADDR = 9'h102;
  localparam int NUM_OUTPUTS = 3;
  // Phase adjust status fields
  localparam int PA_ARMED_BIT = 0;
  localparam int PA_BUSY_BIT = 1;
  localparam int PA_DONE_LATCHED_BIT = 2;
  localparam int PA_DONE_IE_BIT = 3;
  // Output clock status fields
  localparam int OC_HALT_STATE_BIT = 0;
  localparam int OC_HALT_LATCHED_BIT = 1;
  localparam int OC_HALT_IE_BIT = 2;
  localparam int OC_RESUME_LATCHED_BIT = 3;
  localparam int OC_RESUME_IE_BIT = 4;
  localparam int OC_SLOW_LEVEL_BIT = 5;
  localparam int OC_SLOW_EDGE_LATCHED_BIT = 6;
  localparam int OC_SLOW_EDGE_IE_BIT = 7;
  // Configuration fields
  localparam int CFG_BYPASS_BIT = 1;
  localparam int CFG_ENABLE_BIT = 2;
  localparam int SEL_PRIMARY_LSB = 0;
  localparam int SEL_ALT_LSB = 3;
  localparam int SEL_SWITCH_BIT = 6;
  localparam logic [7:0] PA_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Source codes
  localparam logic [2:0] SRC_XTAL = 3'h0;
  localparam logic [2:0] SRC_IN1 = 3'h1;
  localparam logic [2:0] SRC_IN2 = 3'h2;
  localparam logic [2:0] SRC_IN3 = 3'h3;
  localparam logic [2:0] SRC_NCO_BYP_IN1 = 3'h4;
  localparam logic [2:0] SRC_NCO_NO_BYP_MC1 = 3'h5;
  localparam logic [2:0] SRC_NCO_BYP_XA = 3'h6;
  localparam logic [2:0] SRC_NCO_NO_BYP = 3'h7;
  typedef enum logic [2:0] {
    ACP_REF_XTAL, ACP_REF_IN1, ACP_REF_IN2, ACP_REF_IN3, ACP_REF_NCO,
    ACP_REF_NONE
  } acp_ref_type;
endpackage

/* File: rtl/acp_ratio_decode.sv */
// Fast divider code to ratio in half steps
module acp_ratio_decode (
  input wire logic [3:0] code,
  output logic [4:0] ratio_halves
);
  always_comb begin
    if (code[3]) begin
      ratio_halves = {code, 1'b0};
    end else begin
      ratio_halves = 5'h08 + {2'b00, code[2:0]};
    end
  end
endmodule

/* File: rtl/acp_w1c_flag.sv */
// Sticky flag: hardware set, write-one clear, set beats clear
module acp_w1c_flag (
  input wire logic clk,
  input wire logic reset,
  input wire logic set_pulse,
  input wire logic clear_pulse,
  output logic flag
);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (set_pulse) begin
      flag <= 1'b1;
    end else if (clear_pulse) begin
      flag <= 1'b0;
    end
  end
endmodule

/* File: testbench/acp_channel_ctrl_sva.sv */
// Port-level checker for the channel clock path control block
module acp_channel_ctrl_chk
  import acp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic pll_power_enable,
  input wire logic master_clock_from_input1,
  input wire logic xa_doubler_enable,
  input wire logic switch_pin_level,
  input wire logic phase_adjust_irq,
  input wire logic [2:0] output_clock_irq,
  input wire logic second_fast_divider_on,
  input wire logic second_fast_divider_bypass_sel,
  input wire logic [4:0] first_ratio_halves,
  input wire logic [4:0] second_ratio_halves,
  input wire logic [2:0] pll_ref_source,
  input wire logic [2:0] bypass_source,
  input wire logic xa_doubled
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_pa_mask;
    reg_write && reg_addr == PHASE_ADJUST_STATUS_ADDR && !reg_wdata[3];
  endsequence
  sequence s_oc1_mask;
    reg_write && reg_addr == OUTPUT1_CLOCK_STATUS_ADDR &&
      reg_wdata[7] == 1'b0 && reg_wdata[4] == 1'b0 && reg_wdata[2] == 1'b0;
  endsequence
  sequence s_quiet;
    !$past(reg_write) && $stable(switch_pin_level) &&
      $stable(master_clock_from_input1);
  endsequence
  a_pa_irq_mask: assert property (s_pa_mask |=> !phase_adjust_irq)
    else $error("phase irq while its enable is off");
  a_oc_irq_mask: assert property (s_oc1_mask |=> !output_clock_irq[0])
    else $error("output irq while enables are off");
  a_div_on_gate: assert property (second_fast_divider_on |->
    pll_power_enable && !second_fast_divider_bypass_sel)
    else $error("second divider on without its conditions");
  a_bypass_hold: assert property (!$past(reg_write) |->
    $stable(second_fast_divider_bypass_sel))
    else $error("bypass select moved without a write");
  a_ratio_range: assert property (first_ratio_halves >= 5'h08 &&
    first_ratio_halves <= 5'h1e && second_ratio_halves >= 5'h08 &&
    second_ratio_halves <= 5'h1e)
    else $error("divider ratio out of range");
  a_ratio_hold: assert property (!$past(reg_write) |->
    $stable(first_ratio_halves) && $stable(second_ratio_halves))
    else $error("divider ratio moved without a write");
  a_src_hold: assert property (s_quiet |->
    $stable(pll_ref_source) && $stable(bypass_source))
    else $error("source moved without a cause");
  a_xa_pass: assert property (xa_doubled == xa_doubler_enable)
    else $error("doubler flag not passed");
  a_rdata_hold: assert property (!$past(reg_read) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
endmodule

bind acp_channel_ctrl acp_channel_ctrl_chk acp_channel_ctrl_chk_i (
  .clk, .reset, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
  .pll_power_enable, .master_clock_from_input1, .xa_doubler_enable,
  .switch_pin_level, .phase_adjust_irq, .output_clock_irq,
  .second_fast_divider_on, .second_fast_divider_bypass_sel,
  .first_ratio_halves, .second_ratio_halves, .pll_ref_source,
  .bypass_source, .xa_doubled);

/* File: testbench/tb.sv */
// Self-checking bench for the channel clock path control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acp_pkg::*;
  logic clk, reset, reg_write, reg_read, adjust_arm, adjust_trigger;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [2:0] adjust_participate, adjust_output_done, slow_divider_clk;
  logic [2:0] output_clock_stopped, output_path_ready;
  logic [2:0] slow_level_report_enable, output_clock_irq;
  logic [2:0] pll_ref_source, bypass_source;
  logic pll_power_enable, master_clock_from_input1, xa_doubler_enable;
  logic switch_pin_level, phase_adjust_irq, second_fast_divider_on;
  logic second_fast_divider_bypass_sel, xa_doubled;
  logic [4:0] first_ratio_halves, second_ratio_halves;
  int n_mismatch = 0;
  int checks_done = 0;

  acp_channel_ctrl acp_channel_ctrl_i (.clk, .reset, .reg_addr, .reg_write,
    .reg_read, .reg_wdata, .reg_rdata, .adjust_arm, .adjust_trigger,
    .adjust_participate, .adjust_output_done, .slow_divider_clk,
    .output_clock_stopped, .output_path_ready, .slow_level_report_enable,
    .pll_power_enable, .master_clock_from_input1, .xa_doubler_enable,
    .switch_pin_level, .phase_adjust_irq, .output_clock_irq,
    .second_fast_divider_on, .second_fast_divider_bypass_sel,
    .first_ratio_halves, .second_ratio_halves, .pll_ref_source,
    .bypass_source, .xa_doubled);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    d = reg_rdata;
  endtask

  // Status flags settle after an unstated latency, so poll with a bound
  task automatic poll(input logic [8:0] a, input logic [7:0] m,
                      output logic [7:0] d);
    for (int i = 0; i < 20; i++) begin
      rd(a, d);
      if ((d & m) === m) return;
    end
    n_mismatch++;
    give_verdict();
  endtask

  task automatic t_reset;
    logic [8:0] a [7] = '{9'h04d, 9'h053, 9'h054, 9'h055, 9'h100, 9'h101,
                          9'h102};
    foreach (a[i]) begin
      rd(a[i], v);
      chk("reset value", 8'h00, v);
    end
    wr(9'h0ff, 8'hff);
    rd(9'h0ff, v);
    chk("unmapped", 8'h00, v);
    chk("ratio", 8'h08, {3'h0, first_ratio_halves});
    chk("src", 8'h00, {2'h0, pll_ref_source, bypass_source});
  endtask

  task automatic t_phase;
    wr(PHASE_ADJUST_STATUS_ADDR, 8'h08);
    adjust_participate = 3'h3;
    adjust_arm = 1'b1;
    @(negedge clk);
    adjust_arm = 1'b0;
    poll(PHASE_ADJUST_STATUS_ADDR, 8'h01, v);
    chk("armed", 8'h09, v);
    adjust_trigger = 1'b1;
    @(negedge clk);
    adjust_trigger = 1'b0;
    poll(PHASE_ADJUST_STATUS_ADDR, 8'h02, v);
    chk("busy", 8'h0a, v);
    chk("irq early", 8'h00, {7'h0, phase_adjust_irq});
    adjust_output_done = 3'h3;
    poll(PHASE_ADJUST_STATUS_ADDR, 8'h04, v);
    chk("finished", 8'h0c, v);
    chk("irq", 8'h01, {7'h0, phase_adjust_irq});
    wr(PHASE_ADJUST_STATUS_ADDR, 8'h00);
    rd(PHASE_ADJUST_STATUS_ADDR, v);
    chk("zero write", 8'h04, v);
    chk("masked irq", 8'h00, {7'h0, phase_adjust_irq});
    wr(PHASE_ADJUST_STATUS_ADDR, 8'h04);
    rd(PHASE_ADJUST_STATUS_ADDR, v);
    chk("cleared", 8'h00, v);
    adjust_output_done = 3'h0;
  endtask

  task automatic t_status;
    logic [8:0] a;
    output_path_ready = 3'h7;
    for (int n = 0; n < 3; n++) begin
      a = OUTPUT1_CLOCK_STATUS_ADDR + 9'(n);
      wr(a, 8'h94);
      slow_level_report_enable[n] = 1'b1;
      output_clock_stopped[n] = 1'b1;
      poll(a, 8'h02, v);
      chk("stopped", 8'hb7, v);
      chk("irq set", 8'(1 << n), {5'h0, output_clock_irq});
      wr(a, 8'h96);
      rd(a, v);
      chk("stop clear", 8'hb5, v);
      chk("irq clear", 8'h00, {5'h0, output_clock_irq});
      output_clock_stopped[n] = 1'b0;
      poll(a, 8'h08, v);
      chk("resumed", 8'hbc, v);
      slow_divider_clk[n] = 1'b1;
      poll(a, 8'h40, v);
      chk("slow edge", 8'hdc, v);
      slow_divider_clk[n] = 1'b0;
      slow_level_report_enable[n] = 1'b0;
      wr(a, 8'hc8);
      rd(a, v);
      chk("report off", 8'h80, v);
      chk("irq off", 8'h00, {5'h0, output_clock_irq});
      wr(a, 8'h00);
    end
  endtask

  task automatic t_cfg;
    int e1, e2;
    for (int i = 0; i < 8; i++) begin
      pll_power_enable = i[2];
      wr(APLL_DIVIDER_BYPASS_CONFIG_ADDR, {5'h1f, i[1:0], 1'b1});
      chk("div on", {7'h0, i[2] & i[1] & !i[0]},
          {7'h0, second_fast_divider_on});
      chk("bypass", {7'h0, i[0]}, {7'h0, second_fast_divider_bypass_sel});
      rd(APLL_DIVIDER_BYPASS_CONFIG_ADDR, v);
      chk("cfg read", {5'h0, i[1:0], 1'b0}, v);
    end
    for (int c = 0; c < 16; c++) begin
      // Half steps below code 8, whole steps from 8 up
      e1 = (c < 8) ? 8 + c : 2 * c;
      e2 = (c > 7) ? 23 - c : 30 - 2 * c;
      wr(APLL_HIGH_SPEED_RATIOS_ADDR, {4'(15 - c), 4'(c)});
      chk("ratio1", 8'(e1), {3'h0, first_ratio_halves});
      chk("ratio2", 8'(e2), {3'h0, second_ratio_halves});
    end
  endtask

  task automatic t_src;
    logic [2:0] ep [8] = '{0, 1, 2, 3, 4, 4, 4, 4};
    logic [2:0] eb [4] = '{1, 5, 0, 5};
    master_clock_from_input1 = 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(APLL_INPUT_SELECT_ADDR, 8'(c));
      chk("pll src", {5'h0, ep[c]}, {5'h0, pll_ref_source});
      if (c > 3) chk("byp src", {5'h0, eb[c-4]}, {5'h0, bypass_source});
    end
    master_clock_from_input1 = 1'b0;
    wr(APLL_INPUT_SELECT_ADDR, 8'h05);
    chk("no mc1", 8'h05, {5'h0, pll_ref_source});
    chk("no mc1 byp", 8'h05, {5'h0, bypass_source});
    wr(APLL_INPUT_SELECT_ADDR, 8'h51);
    chk("pin low", 8'h01, {5'h0, pll_ref_source});
    switch_pin_level = 1'b1;
    xa_doubler_enable = 1'b1;
    @(negedge clk);
    chk("pin high", 8'h02, {5'h0, pll_ref_source});
    chk("doubled", 8'h01, {7'h0, xa_doubled});
    wr(APLL_INPUT_SELECT_ADDR, 8'h11);
    chk("no switch", 8'h01, {5'h0, pll_ref_source});
    wr(APLL_INPUT_SELECT_ADDR, 8'he9);
    chk("alt unused", 8'h05, {5'h0, pll_ref_source});
    rd(APLL_INPUT_SELECT_ADDR, v);
    chk("sel read", 8'h69, v);
  endtask

  initial begin
    reset = 1'b1;
    {reg_write, reg_read, adjust_arm, adjust_trigger} = 4'h0;
    reg_addr = '0;
    reg_wdata = 8'h00;
    {adjust_participate, adjust_output_done, slow_divider_clk} = 9'h000;
    {output_clock_stopped, output_path_ready} = 6'h00;
    slow_level_report_enable = 3'h0;
    {pll_power_enable, master_clock_from_input1} = 2'h0;
    {xa_doubler_enable, switch_pin_level} = 2'h0;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_phase();
    t_status();
    t_cfg();
    t_src();
    give_verdict();
  end
endmodule
